/* File: design/qs_link.sv */
/*
  Serial-clock side of the interpreter: shifts the control word in on
  falling edges, walks the reply out on rising edges, echo routing.
  Assumes the serial clock stops while chip select is high and that the
  reply word and echo flag stay still throughout a frame.
*/
`default_nettype none
module qs_link (
  // Link clock and resets
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic cs_n,
  // Serial data
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Towards the system domain
  input wire logic [7:0] tx_word,
  input wire logic echo_en,
  output logic [7:0] rx_word_q,
  output logic len_ok_q,
  output logic word_tgl_q
);
  logic [qs_pkg::BIT_CNT_W-1:0] fall_cnt_q;
  logic [qs_pkg::IDX_W-1:0] out_idx_q;
  logic frame_rst_n;

  // Frame counters restart whenever chip select is high
  assign frame_rst_n = rst_n & ~cs_n;

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_cnt_q <= '0;
    end else if (fall_cnt_q != qs_pkg::FULL_CNT) begin
      fall_cnt_q <= fall_cnt_q + 4'h1;
    end
  end

  // Sample on falling edge, MSB first; word and length flag hold past frame
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_q <= qs_pkg::CTRL_WORD_RST; // R17
      len_ok_q <= 1'b0;
      word_tgl_q <= 1'b0;
    end else begin
      rx_word_q <= {rx_word_q[6:0], si}; // R19
      len_ok_q <= (fall_cnt_q == qs_pkg::LAST_BIT); // R21
      if (fall_cnt_q == qs_pkg::LAST_BIT) begin
        word_tgl_q <= ~word_tgl_q;
      end
    end
  end

  // Reply bit index moves on rising edges, one behind the sample count
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_idx_q <= '0;
    end else begin
      out_idx_q <= fall_cnt_q[qs_pkg::IDX_W-1:0];
    end
  end

  always_comb begin
    so_oe = ~cs_n; // R22
    if (cs_n) begin
      so = 1'b0; // R22
    end else if (echo_en && (out_idx_q < qs_pkg::ECHO_LIVE_BITS)) begin
      so = si; // R7
    end else begin
      so = tx_word[qs_pkg::TOP_IDX - out_idx_q]; // R21
    end
  end
endmodule : qs_link
`default_nettype wire

/* File: design/qs_pkg.sv */
/*
  Shared constants and types of the four-channel switch serial command
  interpreter: command codes, word layout, reset values, response states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package qs_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned WORD_W = 8;
  localparam int unsigned BIT_CNT_W = 4;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned SYNC_STAGES = 2;

  // Control word fields
  localparam int unsigned CMD_MSB = 7;
  localparam int unsigned CMD_LSB = 4;
  localparam int unsigned DATA_MSB = 3;
  localparam int unsigned DATA_LSB = 0;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
  localparam logic [BIT_CNT_W-1:0] FULL_CNT = 4'h8;
  localparam logic [IDX_W-1:0] TOP_IDX = 3'h7;
  localparam logic [IDX_W-1:0] ECHO_LIVE_BITS = 3'h4;

  // Command codes
  localparam logic [3:0] CMD_DIAG = 4'h0;
  localparam logic [3:0] CMD_READBACK = 4'hc;
  localparam logic [3:0] CMD_ECHO = 4'ha;
  localparam logic [3:0] CMD_SET_OR = 4'h3;
  localparam logic [3:0] CMD_SET_AND = 4'hf;

  // Diagnosis field codes per channel
  localparam logic [1:0] DIAG_SHORT_GND = 2'h0;
  localparam logic [1:0] DIAG_OPEN_LOAD = 2'h1;
  localparam logic [1:0] DIAG_OVERLOAD = 2'h2;
  localparam logic [1:0] DIAG_NORMAL = 2'h3;

  // Reset values
  localparam logic [7:0] DIAG_WORD_RST = 8'hff;
  localparam logic [7:0] CTRL_WORD_RST = 8'h00;
  localparam logic MODE_AND_RST = 1'b0;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] data;
  } qs_ctrl_word_t;

  typedef enum logic [2:0] {
    RESP_DIAG = 3'b001,
    RESP_READBACK = 3'b010,
    RESP_ECHO = 3'b100
  } qs_resp_t;
endpackage : qs_pkg
`default_nettype wire

/* File: design/qs_spi_top.sv */
/*
  Serial command interpreter of a four-channel output switch: decodes the
  8-bit control word, drives the channels from the parallel inputs through
  the latched OR/AND operation and prepares the reply of the next access.
  Assumes a serial host on sclk/cs_n/si/so and diagnosis levels supplied
  by the power stage; so and so_oe are driven towards a tri-state pad.
*/
//
// Functional notes
// R1 - Bits 7:4 command, 3:0 channel data
// R2 - Diagnosis and read-back ignore data bits
// R3 - Diagnosis command returns diagnosis word next
// R4 - Diagnosis reply lasts one access only
// R5 - Read-back returns inputs then fault flags
// R6 - Echo returns data bits as 3:0
// R7 - Echo routes serial input to output
// R8 - Echo lasts one chip-select period only
// R9 - Command 0011 sets OR, drives in|data
// R10 - Command 1111 sets AND, drives in&data
// R11 - Operation defaults to OR after reset
// R12 - AND holds until OR or reset
// R13 - Set commands return diagnosis word next
// R14 - Other codes apply data with current operation
// R15 - Two-bit channel diagnosis codes
// R16 - Channel n field at bits 2n-1:2n-2
// R17 - Diagnosis resets FF, control word 00
// R18 - Power-on reset restores all defaults
// R19 - Sample serial input on falling clock
// R20 - Host waits fault delay between accesses
// R21 - Eight bits MSB first, act at end
// R22 - Serial output released while deselected
`default_nettype none
module qs_spi_top (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Channel side
  input wire logic [qs_pkg::NUM_CH-1:0] parallel_input_n,
  input wire logic [2*qs_pkg::NUM_CH-1:0] channel_diag_field,
  output logic [qs_pkg::NUM_CH-1:0] chan_out_q,
  output logic boolean_op_mode_q
);
  logic [1:0] rst_pipe_q;
  logic rst_sync_n;
  logic cs_s;
  logic cs_prev_q;
  logic cs_rise;
  logic tgl_s;
  logic tgl_seen_q;
  logic len_ok_s;
  logic word_valid;
  logic [3:0] par_s;
  logic [7:0] diag_s;
  logic [7:0] rx_word;
  logic len_ok_link;
  logic word_tgl_link;
  qs_pkg::qs_ctrl_word_t ctrl_word;
  qs_pkg::qs_ctrl_word_t ctrl_q;
  qs_pkg::qs_resp_t resp_q;
  logic [3:0] data_bits_q;
  logic [7:0] std_diag_q;
  logic [3:0] one_bit_fault_flag;
  logic [7:0] tx_word_q;
  logic echo_en_q;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_q[1];

  qs_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_cs (
    .clk(clk_sys),
    .rst_n(rst_sync_n),
    .d(cs_n),
    .q(cs_s)
  );

  qs_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_sync_link (
    .clk(clk_sys),
    .rst_n(rst_sync_n),
    .d({word_tgl_link, len_ok_link}),
    .q({tgl_s, len_ok_s})
  );

  qs_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_sync_par (
    .clk(clk_sys),
    .rst_n(rst_sync_n),
    .d(parallel_input_n),
    .q(par_s)
  );

  qs_sync #(.WIDTH(8), .RST_VAL(qs_pkg::DIAG_WORD_RST)) u_sync_diag (
    .clk(clk_sys),
    .rst_n(rst_sync_n),
    .d(channel_diag_field),
    .q(diag_s)
  );

  qs_link u_link (
    .sclk(sclk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .tx_word(tx_word_q),
    .echo_en(echo_en_q),
    .rx_word_q(rx_word),
    .len_ok_q(len_ok_link),
    .word_tgl_q(word_tgl_link)
  );

  // End of access: chip select rising, seen after synchronisation
  assign cs_rise = cs_s & ~cs_prev_q;
  // A word counts only if exactly eight bits arrived in this frame
  assign word_valid = cs_rise && len_ok_s && (tgl_s != tgl_seen_q); // R21
  // The received word is still while chip select is high
  assign ctrl_word = qs_pkg::qs_ctrl_word_t'(rx_word); // R1

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs_prev_q <= 1'b1;
      tgl_seen_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      if (cs_rise) begin
        tgl_seen_q <= tgl_s;
      end
    end
  end

  // Last accepted control word
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_q <= qs_pkg::qs_ctrl_word_t'(qs_pkg::CTRL_WORD_RST); // R17 R18
    end else if (word_valid) begin
      ctrl_q <= ctrl_word;
    end
  end

  // Boolean operation mode: 0 = OR, 1 = AND
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boolean_op_mode_q <= qs_pkg::MODE_AND_RST; // R11 R18
    end else if (word_valid) begin
      if (ctrl_word.cmd == qs_pkg::CMD_SET_OR) begin
        boolean_op_mode_q <= 1'b0; // R9
      end else if (ctrl_word.cmd == qs_pkg::CMD_SET_AND) begin
        boolean_op_mode_q <= 1'b1; // R10 R12
      end
    end
  end

  // Channel data bits, kept by commands that ignore or echo them
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_bits_q <= qs_pkg::CTRL_WORD_RST[3:0];
    end else if (word_valid) begin
      case (ctrl_word.cmd)
        qs_pkg::CMD_DIAG: data_bits_q <= data_bits_q; // R2
        qs_pkg::CMD_READBACK: data_bits_q <= data_bits_q; // R2
        qs_pkg::CMD_ECHO: data_bits_q <= data_bits_q;
        default: data_bits_q <= ctrl_word.data; // R14
      endcase
    end
  end

  // Channel drive from parallel inputs and data through the latched operation
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_out_q <= '0;
    end else if (boolean_op_mode_q) begin
      chan_out_q <= par_s & data_bits_q; // R10
    end else begin
      chan_out_q <= par_s | data_bits_q; // R9 R14
    end
  end

  // Reply chosen for the next access only
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      resp_q <= qs_pkg::RESP_DIAG;
    end else if (word_valid) begin
      case (ctrl_word.cmd)
        qs_pkg::CMD_READBACK: resp_q <= qs_pkg::RESP_READBACK; // R5
        qs_pkg::CMD_ECHO: resp_q <= qs_pkg::RESP_ECHO; // R6 R8
        default: resp_q <= qs_pkg::RESP_DIAG; // R3 R4 R13
      endcase
    end else if (cs_rise) begin
      resp_q <= qs_pkg::RESP_DIAG; // R4 R8
    end
  end

  // Standard diagnosis word, channel n at bits 2n-1:2n-2
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      std_diag_q <= qs_pkg::DIAG_WORD_RST; // R17 R18
    end else begin
      std_diag_q <= diag_s; // R15 R16
    end
  end

  // One-bit flag per channel: 1 = normal operation
  genvar ch;
  generate
    for (ch = 0; ch < qs_pkg::NUM_CH; ch++) begin : g_flag
      assign one_bit_fault_flag[ch] =
        (std_diag_q[2*ch+1 -: 2] == qs_pkg::DIAG_NORMAL); // R5
    end
  endgenerate

  // Reply word and echo flag change only while deselected
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_word_q <= qs_pkg::DIAG_WORD_RST;
      echo_en_q <= 1'b0;
    end else if (cs_s && cs_prev_q) begin
      case (resp_q)
        qs_pkg::RESP_DIAG: begin
          tx_word_q <= std_diag_q; // R3 R13
          echo_en_q <= 1'b0;
        end
        qs_pkg::RESP_READBACK: begin
          tx_word_q <= {par_s, one_bit_fault_flag}; // R5
          echo_en_q <= 1'b0;
        end
        qs_pkg::RESP_ECHO: begin
          tx_word_q <= {4'h0, ctrl_q.data}; // R6
          echo_en_q <= 1'b1; // R7 R8
        end
        default: begin
          tx_word_q <= std_diag_q;
          echo_en_q <= 1'b0;
        end
      endcase
    end
  end
endmodule : qs_spi_top
`default_nettype wire

/* File: design/qs_sync.sv */
/*
  Two-stage level synchroniser, one chain per bit.
  Assumes inputs are levels or quasi-static words from another domain.
*/
`default_nettype none
module qs_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("qs_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : qs_sync
`default_nettype wire

/* File: verification/qs_host.sv */
/*
  Serial host model: frames of n bits at a 64 ns serial clock.
  Assumes the device tri-states so while not selected.
*/
`default_nettype none
module qs_host (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe,
  // Captured reply
  output logic [7:0] rx_q,
  output logic rx_tgl
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rx_q = 8'h00;
    rx_tgl = 1'b0;
  end
  task automatic xfer(input logic [7:0] w, input int n);
    logic [7:0] r;
    r = 8'h00;
    #3.3;
    cs_n = 1'b0;
    #256;
    for (int i = 0; i < n; i++) begin
      si = w[7-i];
      #8 sclk = 1'b1;
      #32 r = {r[6:0], so_oe ? so : 1'bz};
      sclk = 1'b0;
      #24;
    end
    si = 1'b0; // Pull-down level once released
    #232 cs_n = 1'b1;
    #256;
    if (n == 8) begin
      rx_q = r;
      rx_tgl = ~rx_tgl;
    end
  endtask : xfer
endmodule : qs_host
`default_nettype wire

/* File: verification/qs_spi_chk.sv */
/*
  Port-level checker of the serial command interpreter.
  Assumes a single clk_sys domain and the rst_n port as its reset.
*/
`default_nettype none
module qs_spi_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial link
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe,
  // Channel side
  input wire logic [qs_pkg::NUM_CH-1:0] parallel_input_n,
  input wire logic [qs_pkg::NUM_CH-1:0] chan_out_q,
  input wire logic boolean_op_mode_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_oe; so_oe == !cs_n; endproperty
  a_oe: assert property (p_oe) else $error("so_oe not tied to select");
  property p_so_idle; cs_n |-> !so; endproperty
  a_so_idle: assert property (p_so_idle) else $error("so active idle");
  property p_mode_rst; $rose(rst_n) |-> !boolean_op_mode_q; endproperty
  a_mode_rst: assert property (p_mode_rst) else $error("mode not OR");
  property p_chan_rst; $rose(rst_n) |-> chan_out_q == 4'h0; endproperty
  a_chan_rst: assert property (p_chan_rst) else $error("chan not 0");
  property p_or;
    (!boolean_op_mode_q && $stable(parallel_input_n)) [*8]
      |-> &(chan_out_q | ~parallel_input_n);
  endproperty
  a_or: assert property (p_or) else $error("OR result lost input");
  property p_and;
    (boolean_op_mode_q && $stable(parallel_input_n)) [*8]
      |-> (chan_out_q & ~parallel_input_n) == 4'h0;
  endproperty
  a_and: assert property (p_and) else $error("AND result above input");
  property p_mode_when;
    $changed(boolean_op_mode_q) |-> cs_n && $past(cs_n, 2);
  endproperty
  a_mode_when: assert property (p_mode_when) else $error("mode in frame");
  property p_mode_hold;
    $changed(boolean_op_mode_q) |=> $stable(boolean_op_mode_q) [*8];
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode flicker");
endmodule : qs_spi_chk

bind qs_spi_top qs_spi_chk qs_spi_chk_inst (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .cs_n(cs_n),
  .so(so),
  .so_oe(so_oe),
  .parallel_input_n(parallel_input_n),
  .chan_out_q(chan_out_q),
  .boolean_op_mode_q(boolean_op_mode_q)
);
`default_nettype wire

/* File: verification/qs_spi_top_tb_top.sv */
/*
  Self-checking bench of the serial command interpreter.
  Assumes the host model and the bound port checker.
*/
`default_nettype none
module qs_spi_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, si, so, so_oe, boolean_op_mode_q, rx_tgl, m_m;
  logic [3:0] pin = 4'h0;
  logic [3:0] chan_out_q, d_m, prev_cmd, prev_data;
  logic [7:0] diag = 8'hff;
  logic [7:0] rx_q;
  logic [7:0] expq [$];
  logic [7:0] seq [8] = '{8'hf5, 8'h06, 8'ha9, 8'ha3, 8'h0f, 8'h00,
                          8'hc7, 8'h35};
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk_sys = ~clk_sys;

  qs_spi_top qs_spi_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .parallel_input_n(pin), .channel_diag_field(diag),
    .chan_out_q(chan_out_q), .boolean_op_mode_q(boolean_op_mode_q));
  qs_host qs_host_inst (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .rx_q(rx_q), .rx_tgl(rx_tgl));

  task automatic cmp_rx(input logic [7:0] a, input logic [7:0] e);
    check_count++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t reply %h exp %h", $time, a, e);
    end
  endtask : cmp_rx
  task automatic cmp_lvl(input logic [3:0] a, input logic [3:0] e);
    check_count++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t level %h exp %h", $time, a, e);
    end
  endtask : cmp_lvl
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  always @(rx_tgl) if (expq.size() > 0) cmp_rx(rx_q, expq.pop_front());
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic frame(input logic [7:0] w, input int n);
    logic [7:0] e;
    logic [3:0] f;
    @(posedge clk_sys);
    pin <= 4'($urandom);
    diag <= 8'($urandom);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) f[i] = &diag[2*i+:2];
    case (prev_cmd)
      qs_pkg::CMD_READBACK: e = {pin, f};
      qs_pkg::CMD_ECHO: e = {w[7:4], prev_data};
      default: e = diag;
    endcase
    if (n == 8) expq.push_back(e);
    qs_host_inst.xfer(w, n);
    repeat (40) @(posedge clk_sys);
    prev_cmd = (n == 8) ? w[7:4] : qs_pkg::CMD_DIAG;
    prev_data = w[3:0];
    if (n == 8) begin
      case (w[7:4])
        qs_pkg::CMD_DIAG, qs_pkg::CMD_READBACK, qs_pkg::CMD_ECHO: ;
        qs_pkg::CMD_SET_OR: begin
          m_m = 1'b0;
          d_m = w[3:0];
        end
        qs_pkg::CMD_SET_AND: begin
          m_m = 1'b1;
          d_m = w[3:0];
        end
        default: d_m = w[3:0];
      endcase
    end
    cmp_lvl(chan_out_q, m_m ? (pin & d_m) : (pin | d_m));
    cmp_lvl({3'h0, boolean_op_mode_q}, {3'h0, m_m});
  endtask : frame

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    m_m = 1'b0;
    d_m = 4'h0;
    prev_cmd = qs_pkg::CMD_DIAG;
    prev_data = 4'h0;
    repeat (8) @(posedge clk_sys);
    cmp_lvl(chan_out_q, pin);
    cmp_lvl({3'h0, boolean_op_mode_q}, 4'h0);
  endtask : do_reset

  initial begin
    void'($urandom(32'hb9661be7));
    do_reset();
    for (int i = 0; i < 16; i++) frame({4'(i), 4'($urandom)}, 8);
    foreach (seq[i]) frame(seq[i], 8);
    frame(8'hf0, 8);
    frame(8'h3c, 7);
    frame(8'h12, 8);
    repeat (20) frame(8'($urandom), 8);
    frame(8'hff, 8);
    do_reset();
    frame(8'h55, 8);
    frame(8'h00, 8);
    print_verdict();
  end
endmodule : qs_spi_top_tb_top
`default_nettype wire
